/* File: core/strap_decode.v */
// Decoder that turns the captured strap code into operating configuration.
`timescale 1ns/100ps
`default_nettype none
`include "strap_loader_consts.vh"

module strap_decode (
  input wire [2:0] code,
  output reg core_enable,
  output reg [1:0] boot_size,
  output reg relocate,
  output reg companion,
  output reg bus_request_out
);

  // ----------------------------------------------------------------------
  // Table decode
  // ----------------------------------------------------------------------
  // Pure table lookup; the caller registers the results.
  always @* begin
    core_enable = 1'b0;
    boot_size = `BOOT_32;
    relocate = 1'b0;
    companion = 1'b0;
    bus_request_out = 1'b1;
    case (code)
      `CFG_SLAVE_8: boot_size = `BOOT_8;
      `CFG_SLAVE_32: boot_size = `BOOT_32;
      `CFG_SLAVE_16: boot_size = `BOOT_16;
      `CFG_COMPANION: begin
        companion = 1'b1;
        bus_request_out = 1'b0;
      end
      `CFG_CORE_32: begin
        core_enable = 1'b1;
        bus_request_out = 1'b0;
      end
      `CFG_CORE_16: begin
        core_enable = 1'b1;
        boot_size = `BOOT_16;
        bus_request_out = 1'b0;
      end
      `CFG_SLAVE_NOBOOT: begin
        boot_size = `BOOT_OFF;
        relocate = 1'b1;
      end
      `CFG_CORE_8: begin
        core_enable = 1'b1;
        boot_size = `BOOT_8;
        bus_request_out = 1'b0;
      end
      default: boot_size = `BOOT_32;
    endcase
  end

endmodule
`default_nettype wire

/* File: core/strap_loader.v */
// Reset strap capture, configuration outputs and keyed base register access.
`timescale 1ns/100ps
`default_nettype none
`include "strap_loader_consts.vh"

module strap_loader (
  input wire clock,
  input wire arst_n,
  input wire sys_reset_n,
  input wire [2:0] config_strap,
  input wire bus_width_strap,
  input wire base_enable_key_pin,
  input wire dma_bus_request,
  input wire bus_request_line_in,
  input wire bus_grant_line_in,
  input wire burst_request,
  input wire reg_strobe,
  input wire reg_write,
  input wire [31:0] reg_addr,
  input wire [3:0] function_code,
  input wire [3:0] reg_byte_en,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  output reg reg_ack,
  output reg reg_miss,
  output reg burst_refused,
  output reg core_enable_q,
  output reg [1:0] boot_size_q,
  output reg companion_q,
  output reg relocated_q,
  output reg wide_bus_q,
  output reg bus_request_line_out,
  output reg bus_request_line_oe,
  output reg bus_grant_line_out,
  output reg bus_grant_line_oe,
  output reg dma_grant,
  output reg [31:0] module_base_q,
  output reg key_select_q,
  output reg [15:0] port_e_assignment_q,
  output reg [15:0] port_e_select_q
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  reg [2:0] cfg_s1_q;
  reg [2:0] cfg_s2_q;
  reg wid_s1_q;
  reg wid_s2_q;
  reg key_s1_q;
  reg key_s2_q;
  reg rst_s1_q;
  reg rst_s2_q;
  reg req_s1_q;
  reg req_s2_q;
  reg gnt_s1_q;
  reg gnt_s2_q;

  // Every strap, reset, key and arbitration pin passes two flops; only the second stage is read anywhere.
  // Mode and width straps. The reset values match the pad pull-ups, so a
  // floating strap reads as code 111 and a wide bus until it is sampled.
  // pull-up default wide
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfg_s1_q <= `STRAP_RESET;
      cfg_s2_q <= `STRAP_RESET;
      wid_s1_q <= `WIDTH_STRAP_RESET;
      wid_s2_q <= `WIDTH_STRAP_RESET;
    end else begin
      cfg_s1_q <= config_strap;
      cfg_s2_q <= cfg_s1_q;
      wid_s1_q <= bus_width_strap;
      wid_s2_q <= wid_s1_q;
    end
  end

  // System reset level. It starts asserted, so the straps keep loading
  // until two clean high samples prove that the reset pin has let go.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= sys_reset_n;
      rst_s2_q <= rst_s1_q;
    end
  end

  // Key enable pin, active low. It starts at the idle high level, so no
  // unlock can be taken from a stale sample right after reset.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      key_s1_q <= 1'b1;
      key_s2_q <= 1'b1;
    end else begin
      key_s1_q <= base_enable_key_pin;
      key_s2_q <= key_s1_q;
    end
  end

  // Arbitration pins. Only the second stage is read, by the bus logic below.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      gnt_s1_q <= 1'b0;
      gnt_s2_q <= 1'b0;
    end else begin
      req_s1_q <= bus_request_line_in;
      req_s2_q <= req_s1_q;
      gnt_s1_q <= bus_grant_line_in;
      gnt_s2_q <= gnt_s1_q;
    end
  end

  // ----------------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------------
  reg [2:0] code_q;
  wire dec_core;
  wire [1:0] dec_boot;
  wire dec_reloc;
  wire dec_comp;
  wire dec_req_out;

  strap_decode u_decode (
    .code(code_q),
    .core_enable(dec_core),
    .boot_size(dec_boot),
    .relocate(dec_reloc),
    .companion(dec_comp),
    .bus_request_out(dec_req_out)
  );

  // Straps are captured by a clocked process while system reset is held,
  // never by the asynchronous reset, so a pin value is not loaded async.
  // sample during reset
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      code_q <= `STRAP_RESET;
      wide_bus_q <= `WIDTH_STRAP_RESET;
    end else if (!rst_s2_q) begin
      code_q <= cfg_s2_q;
      wide_bus_q <= wid_s2_q;
    end
    // Released: code and width hold until the next system reset.
    // hold after release
  end

  // Configuration outputs are registered copies of the decode. They lag the
  // captured code by one edge and stand still once the code stops loading.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      core_enable_q <= 1'b1;
      boot_size_q <= `BOOT_8;
      companion_q <= 1'b0;
      relocated_q <= 1'b0;
    end else begin
      core_enable_q <= dec_core;
      boot_size_q <= dec_boot;
      companion_q <= dec_comp;
      relocated_q <= dec_reloc;
    end
  end

  // Arbitration pin directions. Both drivers stay off through the async
  // reset, so nothing fights the outside master before a code is known.
  // arbitration pin direction
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bus_request_line_oe <= 1'b0;
      bus_grant_line_oe <= 1'b0;
    end else begin
      bus_request_line_oe <= dec_req_out;
      bus_grant_line_oe <= ~dec_req_out;
    end
  end

  // ----------------------------------------------------------------------
  // Bus arbitration for the DMA engines
  // ----------------------------------------------------------------------
  // When the core is off, outside companion mode, the DMA engines ask the outside master for the bus
  // on the request line and own it once the grant line answers.
  // The grant passes the pin synchroniser and the grant register, so it counts three edges after the
  // pin moves; the outside master must hold it at least that long.
  // DMA owns bus
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bus_request_line_out <= 1'b0;
      bus_grant_line_out <= 1'b0;
      dma_grant <= 1'b0;
    end else if (bus_request_line_oe) begin
      bus_request_line_out <= dma_bus_request;
      bus_grant_line_out <= 1'b0;
      dma_grant <= dma_bus_request & gnt_s2_q;
    end else begin
      // Grant driven outward: pass the synchronised outside request on, one edge
      // after its second stage, while no internal DMA wants the bus.
      bus_request_line_out <= 1'b0;
      bus_grant_line_out <= req_s2_q & ~dma_bus_request;
      dma_grant <= dma_bus_request & ~req_s2_q;
    end
  end

  // ----------------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------------
  // Byte lane mask built from the four byte enables.
  function [31:0] lane_mask;
    input [3:0] be;
    begin
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  // Access decode. The relocated pair answers only CPU space; port E is
  // open to every function code outside DMA space.
  wire cpu_space = (function_code == `FC_CPU_SPACE);
  wire [31:0] base_loc = relocated_q ? `BASE_ADDR_RELOC : `BASE_ADDR_DEFAULT;
  wire hit_base = cpu_space && (reg_addr == base_loc);
  wire hit_key = cpu_space && relocated_q && (reg_addr == `KEY_ADDR);
  wire hit_pe = (reg_addr == `PORT_E_ADDR) && !function_code[`FC_DMA_BIT];
  wire base_open = !relocated_q || key_select_q;
  // no burst support with the core off
  // A burst is refused whole while the core is off; refusing only the
  // answer would still let its write land in a register.
  wire refused = burst_request && !core_enable_q;
  wire take = reg_strobe && !refused;
  wire take_write = take && reg_write;
  wire hit_any = (hit_base && base_open) || hit_key || hit_pe;
  wire [31:0] lanes = lane_mask(reg_byte_en);
  wire [31:0] wmask = lanes & `BASE_WRITE_MASK;
  wire [15:0] pe_mask = lanes[15:0];

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Module base register. It reloads its reset value for the whole system
  // reset, so a base written before the straps settle never survives. A
  // locked or refused write leaves it untouched.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      module_base_q <= `BASE_RESET;
    end else if (!rst_s2_q) begin
      module_base_q <= `BASE_RESET;
    end else if (take_write && hit_base && base_open) begin
      // Bits 12:9 are masked so they always read as zero.
      module_base_q <= (module_base_q & ~wmask) | (reg_wdata & wmask);
    end
  end

  // Select bit of the enable key. The key write and the low-byte base write
  // sit at different addresses, so a set and a clear never meet in one
  // cycle; were they to, the later assignment, the set, would win.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      key_select_q <= 1'b0;
    end else if (!rst_s2_q) begin
      key_select_q <= 1'b0;
    end else if (take_write) begin
      if (hit_base && base_open && reg_byte_en[0]) begin
        key_select_q <= 1'b0;
      end
      if (hit_key && reg_byte_en[3] && reg_wdata[`KEY_SEL_BIT] && !key_s2_q) begin
        key_select_q <= 1'b1;
      end
    end
  end

  // Port E assignment register, written lane by lane. It clears during the
  // system reset like the module base and key select registers.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      port_e_assignment_q <= `PORT_E_RESET;
    end else if (!rst_s2_q) begin
      port_e_assignment_q <= `PORT_E_RESET;
    end else if (take_write && hit_pe) begin
      port_e_assignment_q <= (port_e_assignment_q & ~pe_mask) | (reg_wdata[15:0] & pe_mask);
    end
  end

  // Read data. It is loaded on every taken access and holds until the
  // next one, so the master may take it with the acknowledge or later.
  // Misses load zero so no stale register value leaks onto the bus.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (take) begin
      if (hit_base && base_open) begin
        reg_rdata <= module_base_q;
      end else if (hit_key) begin
        reg_rdata <= {key_select_q, 31'h00000000};
      end else if (hit_pe) begin
        reg_rdata <= {16'h0000, port_e_assignment_q};
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end
  end

  // One-cycle answer pulses. Unmapped or locked accesses get a miss so the
  // outside bus can run an external cycle instead; exactly one of the three
  // pulses follows every strobe.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_ack <= 1'b0;
      reg_miss <= 1'b0;
      burst_refused <= 1'b0;
    end else begin
      reg_ack <= take && hit_any;
      reg_miss <= take && !hit_any;
      burst_refused <= reg_strobe && refused;
    end
  end

  // ----------------------------------------------------------------------
  // Port E pin function select
  // ----------------------------------------------------------------------
  // Each pin takes its own two-bit function code from the assignment
  // register, one edge later. The decode of each code into a pin function
  // sits with the pads; this block only holds and presents the selection.
  // per-pin function select
  integer i;
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      port_e_select_q <= `PORT_E_RESET;
    end else begin
      for (i = 0; i < `PORT_E_PINS; i = i + 1) begin
        port_e_select_q[2*i +: 2] <= port_e_assignment_q[2*i +: 2];
      end
    end
  end

endmodule
`default_nettype wire

/* File: core/strap_loader_consts.vh */
// Constants for the reset strap loader and the base register unlock logic.
`ifndef STRAP_LOADER_CONSTS_VH
`define STRAP_LOADER_CONSTS_VH

// ----------------------------------------------------------------------
// Register addresses and function codes
// ----------------------------------------------------------------------
`define BASE_ADDR_DEFAULT 32'h0003FF00
`define BASE_ADDR_RELOC 32'h0003FF04
`define KEY_ADDR 32'h0003FF08
`define FC_CPU_SPACE 4'h7
`define FC_DMA_BIT 3

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define KEY_SEL_BIT 31
`define BASE_RESET 32'h00000000
`define BASE_WRITE_MASK 32'hFFFFE1FF
`define STRAP_RESET 3'h7
`define WIDTH_STRAP_RESET 1'h1

// ----------------------------------------------------------------------
// Strap codes
// ----------------------------------------------------------------------
`define CFG_SLAVE_8 3'h0
`define CFG_SLAVE_32 3'h1
`define CFG_SLAVE_16 3'h2
`define CFG_COMPANION 3'h3
`define CFG_CORE_32 3'h4
`define CFG_CORE_16 3'h5
`define CFG_SLAVE_NOBOOT 3'h6
`define CFG_CORE_8 3'h7

// Boot select port size encodings.
`define BOOT_OFF 2'h0
`define BOOT_8 2'h1
`define BOOT_16 2'h2
`define BOOT_32 2'h3

// Port E: eight pins, two select bits per pin.
`define PORT_E_PINS 8
`define PORT_E_ADDR 32'h0003FF0C
`define PORT_E_RESET 16'h0000

`endif

/* File: verif/host_model.sv */
// Host bus master model that runs register cycles and drives the key pin.
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic clock,
  input wire logic reg_ack,
  input wire logic reg_miss,
  input wire logic burst_refused,
  input wire logic [31:0] reg_rdata,
  output logic reg_strobe = 1'b0,
  output logic reg_write = 1'b0,
  output logic [31:0] reg_addr = 32'h0,
  output logic [3:0] function_code = 4'h0,
  output logic [3:0] reg_byte_en = 4'h0,
  output logic [31:0] reg_wdata = 32'h0,
  output logic burst_request = 1'b0,
  output logic key_pin_n = 1'b1
);
  // One strobe cycle; the answer is taken at the second edge after the strobe.
  task automatic cycle(input logic wr, input logic [31:0] a, input logic [3:0] fc,
    input logic [3:0] be, input logic [31:0] d, input logic bu,
    output logic [31:0] rd, output logic [2:0] rsp);
    reg_strobe <= 1'b1;
    reg_write <= wr;
    reg_addr <= a;
    function_code <= fc;
    reg_byte_en <= be;
    reg_wdata <= d;
    burst_request <= bu;
    @(posedge clock);
    reg_strobe <= 1'b0;
    // Released address and data show the inverse, so stale values never look valid.
    reg_addr <= ~a;
    reg_wdata <= ~d;
    @(posedge clock);
    rd = reg_rdata;
    rsp = {reg_ack, reg_miss, burst_refused};
  endtask

  task automatic key_slave(input int idx, input logic [3:0] fc, output logic [2:0] rsp);
    logic [31:0] rd;
    // Let an edge pass so the pin is never assigned twice in one time step.
    @(posedge clock);
    key_pin_n <= (idx != 0);
    repeat (4) @(posedge clock);
    cycle(1'b1, 32'h0003FF08, fc, 4'hF, ~(32'h1 << idx), 1'b0, rd, rsp);
    key_pin_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: verif/strap_loader_props.sv */
// Concurrent checks on the strap loader ports.
`timescale 1ns/100ps
`default_nettype none
module strap_loader_props (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic sys_reset_n,
  input wire logic reg_strobe,
  input wire logic reg_write,
  input wire logic [31:0] reg_addr,
  input wire logic [3:0] function_code,
  input wire logic [3:0] reg_byte_en,
  input wire logic burst_request,
  input wire logic reg_ack,
  input wire logic reg_miss,
  input wire logic burst_refused,
  input wire logic core_enable_q,
  input wire logic [1:0] boot_size_q,
  input wire logic companion_q,
  input wire logic relocated_q,
  input wire logic wide_bus_q,
  input wire logic bus_request_line_oe,
  input wire logic bus_grant_line_oe,
  input wire logic [31:0] module_base_q,
  input wire logic key_select_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  // A CPU-space access to the relocated base, and that same access as an unlocked low-byte write.
  sequence s_reloc;
    reg_strobe && reg_addr == 32'h0003FF04 && function_code == 4'h7 && relocated_q;
  endsequence
  sequence s_low_write;
    s_reloc ##0 (reg_write && reg_byte_en[0] && key_select_q);
  endsequence

  chk_answer_next: assert property (reg_strobe && sys_reset_n |=> reg_ack || reg_miss || burst_refused)
    else $error("access got no answer");
  chk_no_stray: assert property (!reg_strobe |=> !reg_ack && !reg_miss)
    else $error("answer without access");
  chk_lock_refuses: assert property (s_reloc ##0 !key_select_q |=> reg_miss && $stable(module_base_q))
    else $error("locked base was reachable");
  chk_low_relock: assert property (s_low_write |=> !key_select_q)
    else $error("low byte write kept the key");
  chk_key_cpu_only: assert property (reg_strobe && reg_write && reg_addr == 32'h0003FF08
    && function_code != 4'h7 && !key_select_q |=> !key_select_q)
    else $error("key set outside CPU space");
  chk_straps_held: assert property (sys_reset_n [*5] |=> $stable(core_enable_q)
    && $stable(boot_size_q) && $stable(wide_bus_q))
    else $error("configuration moved after reset");
  chk_reloc_noboot: assert property (relocated_q |-> boot_size_q == 2'h0 && !core_enable_q)
    else $error("relocation outside code 110");
  chk_slave_arb: assert property (sys_reset_n && !core_enable_q && !companion_q && boot_size_q == 2'h3
    ##1 $stable(boot_size_q) |-> bus_request_line_oe && !bus_grant_line_oe)
    else $error("slave arbitration direction wrong");
  chk_comp_arb: assert property (sys_reset_n && companion_q ##1 companion_q |-> !bus_request_line_oe)
    else $error("companion drives request line");
  chk_burst_refused: assert property (reg_strobe && burst_request && !core_enable_q |=> burst_refused)
    else $error("burst not refused");
endmodule

bind strap_loader strap_loader_props chk_i (.clock, .arst_n, .sys_reset_n, .reg_strobe, .reg_write,
  .reg_addr, .function_code, .reg_byte_en, .burst_request, .reg_ack, .reg_miss, .burst_refused,
  .core_enable_q, .boot_size_q, .companion_q, .relocated_q, .wide_bus_q, .bus_request_line_oe,
  .bus_grant_line_oe, .module_base_q, .key_select_q);
`default_nettype wire

/* File: verif/tb_reset_strap_and_base_unlock.sv */
// Self-checking bench for the strap loader against expected values computed in the bench.
`timescale 1ns/100ps
`default_nettype none
module tb_reset_strap_and_base_unlock;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic sys_reset_n = 1'b0;
  logic [2:0] config_strap = 3'h0;
  logic bus_width_strap = 1'b1;
  logic dma_bus_request = 1'b0;
  logic bus_request_line_in = 1'b1;
  logic bus_grant_line_in = 1'b0;
  logic key_pin_n, reg_strobe, reg_write, burst_request, reg_ack, reg_miss, burst_refused;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, module_base_q, rd, d;
  logic [3:0] function_code, reg_byte_en;
  logic core_enable_q, companion_q, relocated_q, wide_bus_q, dma_grant, key_select_q;
  logic [1:0] boot_size_q;
  logic [15:0] port_e_assignment_q;
  logic [15:0] port_e_select_q;
  logic bus_request_line_out, bus_grant_line_out;
  logic [2:0] rsp;
  int miscompares = 0;
  int checked = 0;
  int exp_boot [8] = '{1, 3, 2, 3, 3, 2, 0, 1};

  // Half-period toggle for the 40 MHz clock.
  always #12.5 clock = ~clock;

  strap_loader dut (.clock, .arst_n, .sys_reset_n, .config_strap, .bus_width_strap,
    .base_enable_key_pin(key_pin_n), .dma_bus_request, .bus_request_line_in, .bus_grant_line_in,
    .burst_request, .reg_strobe, .reg_write, .reg_addr, .function_code, .reg_byte_en, .reg_wdata,
    .reg_rdata, .reg_ack, .reg_miss, .burst_refused, .core_enable_q, .boot_size_q, .companion_q,
    .relocated_q, .wide_bus_q, .bus_request_line_out, .bus_request_line_oe(),
    .bus_grant_line_out, .bus_grant_line_oe(), .dma_grant, .module_base_q, .key_select_q,
    .port_e_assignment_q, .port_e_select_q);

  host_model host (.clock, .reg_ack, .reg_miss, .burst_refused, .reg_rdata, .reg_strobe,
    .reg_write, .reg_addr, .function_code, .reg_byte_en, .reg_wdata, .burst_request, .key_pin_n);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic wr, input logic [31:0] a, input logic [3:0] be, input logic bu);
    host.cycle(wr, a, 4'h7, be, d, bu, rd, rsp);
  endtask

  // Straps are presented during system reset, then inverted to show they are ignored.
  task automatic boot(input logic [2:0] code, input logic w);
    sys_reset_n <= 1'b0;
    config_strap <= code;
    bus_width_strap <= w;
    repeat (5) @(posedge clock);
    sys_reset_n <= 1'b1;
    repeat (5) @(posedge clock);
    config_strap <= ~code;
    bus_width_strap <= ~w;
    repeat (3) @(posedge clock);
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake.
  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    report_and_stop();
  end

  initial begin
    logic core;
    logic w;
    logic got;
    void'($urandom(10498));
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      core = (c == 4 || c == 5 || c == 7);
      w = core ? 1'($urandom_range(1)) : 1'b1;
      bus_request_line_in <= 1'($urandom_range(1));
      boot(3'(c), w);
      chk(core_enable_q, core);
      chk(boot_size_q, exp_boot[c]);
      chk(companion_q, c == 3);
      chk(relocated_q, c == 6);
      chk(wide_bus_q, w);
      d = $urandom;
      if (c != 6) begin
        acc(1'b1, 32'h0003FF00, 4'hF, 1'b0);
        chk(rsp, 3'b100);
        acc(1'b0, 32'h0003FF00, 4'hF, 1'b0);
        chk(rd, d & 32'hFFFFE1FF);
      end else begin
        chk(key_select_q, 1'b0);
        acc(1'b1, 32'h0003FF04, 4'hF, 1'b0);
        chk(rsp, 3'b010);
        host.key_slave(1, 4'h7, rsp);
        acc(1'b1, 32'h0003FF04, 4'hF, 1'b0);
        chk(rsp, 3'b010);
        host.key_slave(0, 4'h5, rsp);
        chk(key_select_q, 1'b0);
        host.key_slave(0, 4'h7, rsp);
        chk(key_select_q, 1'b1);
        acc(1'b1, 32'h0003FF04, 4'hE, 1'b0);
        chk(key_select_q, 1'b1);
        acc(1'b1, 32'h0003FF04, 4'hF, 1'b0);
        chk(key_select_q, 1'b0);
        chk(module_base_q, d & 32'hFFFFE1FF);
        acc(1'b1, 32'h0003FF04, 4'hF, 1'b0);
        chk(rsp, 3'b010);
      end
      acc(1'b0, 32'h0003FF00, 4'hF, 1'b1);
      chk(rsp, core ? 3'b100 : 3'b001);
      host.cycle(1'b1, 32'h0003FF0C, 4'h5, 4'hF, d, 1'b0, rd, rsp);
      chk(port_e_assignment_q, d[15:0]);
      @(posedge clock);
      chk(port_e_select_q, d[15:0]);
      if (!core && c != 3) begin
        dma_bus_request <= 1'b1;
        got = 1'b0;
        // Grant rises at the fifth edge; it must not count before the pin does.
        for (int k = 0; k < 10; k++) begin
          @(posedge clock);
          bus_grant_line_in <= (k > 3);
          @(negedge clock);
          if (k == 3) begin
            chk(dma_grant, 1'b0);
          end
          got = got | (dma_grant === 1'b1);
        end
        chk(got, 1'b1);
        chk(bus_request_line_out, 1'b1);
        @(posedge clock);
        dma_bus_request <= 1'b0;
        bus_grant_line_in <= 1'b0;
      end else begin
        chk(bus_grant_line_out, bus_request_line_in);
      end
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
